/* verilog/esx_unit.sv */
// Decode and execution of the extended stack instructions and indexed offset addressing
// Assumes one instruction word per clock, a memory read that answers in the same cycle as
// its address, and a sequencer that honours the push, pop and load requests
`timescale 1ns/10ps
`include "esx_defines.svh"

// Function
// - Accumulator call pushes counter plus two
// - Call target is latches and accumulator
// - Call takes two cycles, flags untouched
// - Indexed source to absolute destination move
// - Whole 4096-byte space valid for moves
// - Indirect source register reads as zero
// - Indexed-to-indexed move: both addresses frame-relative
// - Indirect destination makes indexed-to-indexed move a no-op
// - Push literal, then decrement frame pointer
// - Subtract literal from selected pointer
// - Select three subtracts frame, then returns
// - Extension adds opcodes and indexed addressing
// - Disabled: access bank or selected bank
// - Enabled low operand offsets frame pointer
// - Indexed address is plain sum
// - Configuration bit gates all extended behaviour
module esx_unit import esx_pkg::*; #(
	parameter int IND_COUNT = `ESX_IND_COUNT,
	parameter logic [11:0] IND_BASE = `ESX_IND_BASE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ext_enable,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire esx_pc_t pc,
	input wire logic [7:0] accumulator_reg,
	input wire logic [7:0] counter_high_latch,
	input wire logic [7:0] counter_upper_latch,
	input wire esx_pc_t return_stack_top,
	input wire logic [3:0] bank_selector,
	input wire logic std_valid,
	input wire logic [7:0] std_file,
	input wire logic std_access,
	input wire logic ptr_load,
	input wire logic [1:0] ptr_sel,
	input wire esx_addr_t ptr_value,
	input wire logic [7:0] mem_rd_data,
	output logic claim_r,
	output logic busy_r,
	output logic stack_push_r,
	output esx_pc_t stack_push_value_r,
	output logic stack_pop_r,
	output logic pc_load_r,
	output esx_pc_t pc_load_value_r,
	output logic mem_rd_en_r,
	output esx_addr_t mem_rd_addr_r,
	output logic mem_wr_en_r,
	output esx_addr_t mem_wr_addr_r,
	output logic [7:0] mem_wr_data_r,
	output logic eff_valid_r,
	output esx_addr_t eff_addr_r,
	output esx_addr_t pointer0,
	output esx_addr_t pointer1,
	output esx_addr_t pointer2
);
	esx_state_e state_r;
	esx_state_e state_nxt;
	esx_addr_t ptr_r [3];
	esx_addr_t frame_pointer;
	logic src_ind_r;

	// Decode of the first word
	wire dec = (state_r == ESX_DEC) && instr_valid && ext_enable;
	wire is_call = dec && (instr_word == `ESX_OP_CALL);
	wire is_movs = dec && (instr_word[15:8] == `ESX_OP_MOVS);
	wire is_move_indexed_to_absolute = is_movs && !instr_word[7];
	wire is_move_indexed_to_indexed = is_movs && instr_word[7];
	wire is_push = dec && (instr_word[15:8] == `ESX_OP_PUSH);
	wire is_sub = dec && (instr_word[15:8] == `ESX_OP_SUB);
	wire sub_ret = is_sub && (instr_word[7:6] == `ESX_SEL_RET);
	wire sub_ptr = is_sub && !sub_ret;
	wire claim = is_call || is_movs || is_push || is_sub;
	wire [5:0] sub_k = instr_word[5:0];

	// Second word of the moves
	wire in_w2 = (state_r == ESX_MVSF) || (state_r == ESX_MVSS);
	wire w2_ok = in_w2 && instr_valid && (instr_word[15:12] == `ESX_W2_NIB);

	// Frame-relative and absolute move addresses, wrapping in twelve bits
	assign frame_pointer = ptr_r[2];
	wire esx_addr_t frame_off = 12'(frame_pointer + {5'h00, instr_word[6:0]});
	wire esx_addr_t src_addr = frame_off;
	wire esx_addr_t dst_addr = (state_r == ESX_MVSS) ? frame_off : instr_word[11:0];
	wire src_ind;
	wire dst_ind;

	esx_ind_detect #(.COUNT(IND_COUNT), .BASE(IND_BASE)) u_src_ind (
		.addr(src_addr),
		.hit(src_ind)
	);

	esx_ind_detect #(.COUNT(IND_COUNT), .BASE(IND_BASE)) u_dst_ind (
		.addr(dst_addr),
		.hit(dst_ind)
	);

	// Sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ESX_DEC: begin
				if (is_move_indexed_to_absolute) begin
					state_nxt = ESX_MVSF;
				end else if (is_move_indexed_to_indexed) begin
					state_nxt = ESX_MVSS;
				end else if (is_call || sub_ret) begin
					state_nxt = ESX_IDLE;
				end
			end
			ESX_MVSF: state_nxt = ESX_DEC;
			ESX_MVSS: state_nxt = ESX_DEC;
			ESX_IDLE: state_nxt = ESX_DEC;
			default: state_nxt = ESX_DEC;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ESX_DEC;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Pointer file; extended operations win over a plain load
	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_ptr
			wire sel_me = (ptr_sel == 2'(gp));
			wire is_frame = (gp == 2);
			esx_addr_t ptr_nxt;
			always_comb begin
				ptr_nxt = ptr_r[gp];
				if (sub_ptr && (instr_word[7:6] == 2'(gp))) begin
					ptr_nxt = 12'(ptr_r[gp] - {6'h00, sub_k});
				end else if (sub_ret && is_frame) begin
					ptr_nxt = 12'(ptr_r[gp] - {6'h00, sub_k});
				end else if (is_push && is_frame) begin
					ptr_nxt = 12'(ptr_r[gp] - 12'h001);
				end else if (ptr_load && sel_me) begin
					ptr_nxt = ptr_value;
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					ptr_r[gp] <= `ESX_PTR_RESET;
				end else begin
					ptr_r[gp] <= ptr_nxt;
				end
			end
		end
	endgenerate

	assign pointer0 = ptr_r[0];
	assign pointer1 = ptr_r[1];
	assign pointer2 = ptr_r[2];

	// Program flow requests; no path to status, accumulator or bank exists here
	wire esx_pc_t call_target = {counter_upper_latch[4:0], counter_high_latch, accumulator_reg};
	wire esx_pc_t pc_ret = 21'(pc + `ESX_PC_STEP);
	wire pc_load_nxt = is_call || sub_ret;
	wire esx_pc_t pc_value_nxt = is_call ? call_target : return_stack_top;

	always_ff @(posedge clk) begin
		if (rst) begin
			stack_push_r <= 1'b0;
			stack_pop_r <= 1'b0;
			pc_load_r <= 1'b0;
		end else begin
			stack_push_r <= is_call;
			stack_pop_r <= sub_ret;
			pc_load_r <= pc_load_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stack_push_value_r <= `ESX_PC_RESET;
			pc_load_value_r <= `ESX_PC_RESET;
		end else begin
			stack_push_value_r <= is_call ? pc_ret : stack_push_value_r;
			pc_load_value_r <= pc_load_nxt ? pc_value_nxt : pc_load_value_r;
		end
	end

	// Data memory side
	wire wr_move = w2_ok && !((state_r == ESX_MVSS) && dst_ind);
	wire wr_en_nxt = is_push || wr_move;
	wire esx_addr_t wr_addr_nxt = is_push ? frame_pointer : dst_addr;
	wire [7:0] move_data = src_ind_r ? `ESX_BYTE_RESET : mem_rd_data;
	wire [7:0] wr_data_nxt = is_push ? instr_word[7:0] : move_data;

	always_ff @(posedge clk) begin
		if (rst) begin
			mem_rd_en_r <= 1'b0;
			mem_rd_addr_r <= `ESX_ADDR_RESET;
			src_ind_r <= 1'b0;
		end else begin
			mem_rd_en_r <= is_movs;
			mem_rd_addr_r <= is_movs ? src_addr : mem_rd_addr_r;
			src_ind_r <= is_movs ? src_ind : src_ind_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mem_wr_en_r <= 1'b0;
			mem_wr_addr_r <= `ESX_ADDR_RESET;
			mem_wr_data_r <= `ESX_BYTE_RESET;
		end else begin
			mem_wr_en_r <= wr_en_nxt;
			mem_wr_addr_r <= wr_en_nxt ? wr_addr_nxt : mem_wr_addr_r;
			mem_wr_data_r <= wr_en_nxt ? wr_data_nxt : mem_wr_data_r;
		end
	end

	// Standard operand address mapping
	wire std_low = (std_file <= `ESX_ACCESS_LIMIT);
	wire esx_addr_t std_indexed = 12'(frame_pointer + {4'h0, std_file});
	wire esx_addr_t std_access_addr = std_low ? {4'h0, std_file} : {`ESX_ACCESS_HI, std_file};
	wire esx_addr_t std_bank_addr = {bank_selector, std_file};
	wire use_index = ext_enable && !std_access && std_low;
	wire esx_addr_t eff_nxt = std_access ? std_bank_addr :
		(use_index ? std_indexed : std_access_addr);

	always_ff @(posedge clk) begin
		if (rst) begin
			eff_valid_r <= 1'b0;
			eff_addr_r <= `ESX_ADDR_RESET;
		end else begin
			eff_valid_r <= std_valid;
			eff_addr_r <= std_valid ? eff_nxt : eff_addr_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			claim_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			claim_r <= claim;
			busy_r <= (state_nxt != ESX_DEC);
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	call_push_ret_a: assert property (is_call |=> stack_push_r &&
		stack_push_value_r == 21'($past(pc) + `ESX_PC_STEP))
		else $error("call did not push counter plus two");

	call_target_a: assert property (is_call |=> pc_load_r && !stack_pop_r &&
		pc_load_value_r == {$past(counter_upper_latch[4:0]), $past(counter_high_latch),
		$past(accumulator_reg)})
		else $error("call target mismatch");

	call_two_cycles_a: assert property (is_call |=> busy_r ##1 !busy_r && !pc_load_r)
		else $error("call did not take exactly two cycles");

	move_indexed_to_absolute_addr_a: assert property (is_move_indexed_to_absolute |=> mem_rd_en_r &&
		mem_rd_addr_r == 12'($past(frame_pointer) + {5'h00, $past(instr_word[6:0])}))
		else $error("absolute move source address wrong");

	move_indexed_to_absolute_dest_a: assert property (state_r == ESX_MVSF && w2_ok |=> mem_wr_en_r &&
		mem_wr_addr_r == $past(instr_word[11:0]))
		else $error("absolute move destination address wrong");

	src_zero_a: assert property (mem_rd_en_r && src_ind_r ##1 mem_wr_en_r |->
		mem_wr_data_r == 8'h00)
		else $error("indirect source did not read as zero");

	dst_nop_a: assert property (state_r == ESX_MVSS && dst_ind |=> !mem_wr_en_r)
		else $error("indirect destination was written");

	push_a: assert property (is_push |=> mem_wr_en_r &&
		mem_wr_addr_r == $past(frame_pointer) && mem_wr_data_r == $past(instr_word[7:0]) &&
		frame_pointer == 12'($past(frame_pointer) - 12'h001))
		else $error("push literal wrong");

	sub_ptr_a: assert property (sub_ptr && instr_word[7:6] == 2'h0 |=> !busy_r &&
		pointer0 == 12'($past(pointer0) - {6'h00, $past(sub_k)}))
		else $error("pointer subtract wrong");

	sub_ret_a: assert property (sub_ret |=> stack_pop_r && pc_load_r && busy_r &&
		pointer2 == 12'($past(pointer2) - {6'h00, $past(sub_k)}) &&
		pc_load_value_r == $past(return_stack_top) ##1 !busy_r)
		else $error("subtract and return wrong");

	disabled_a: assert property (!ext_enable |=> !claim_r)
		else $error("extended opcode taken while disabled");

	indexed_a: assert property (std_valid && ext_enable && !std_access && std_low |=>
		eff_addr_r == 12'($past(frame_pointer) + {4'h0, $past(std_file)}))
		else $error("indexed operand address wrong");

	bank_a: assert property (std_valid && std_access |=>
		eff_addr_r == {$past(bank_selector), $past(std_file)})
		else $error("banked operand address wrong");

	call_c: cover property (is_call ##2 state_r == ESX_DEC);
	move_indexed_to_indexed_c: cover property (is_move_indexed_to_indexed ##1 w2_ok ##1 mem_wr_en_r);
	push_c: cover property (is_push ##1 is_push);
	ret_c: cover property (sub_ret ##1 busy_r);
endmodule : esx_unit

/* pkg/esx_defines.svh */
// Opcode patterns, address fields and reset values for the extended stack instruction unit
// Assumes inclusion by bare name from the design modules
`ifndef ESX_DEFINES_SVH
`define ESX_DEFINES_SVH

`define ESX_OP_CALL 16'h0014
`define ESX_OP_MOVS 8'hEB
`define ESX_OP_PUSH 8'hFA
`define ESX_OP_SUB 8'hE9
`define ESX_W2_NIB 4'hF
`define ESX_SEL_FRAME 2'h2
`define ESX_SEL_RET 2'h3
`define ESX_PC_STEP 21'h000002
`define ESX_ACCESS_LIMIT 8'h5F
`define ESX_ACCESS_HI 4'hF
`define ESX_IND_BASE 12'hFD0
`define ESX_IND_COUNT 15
`define ESX_PTR_RESET 12'h000
`define ESX_ADDR_RESET 12'h000
`define ESX_PC_RESET 21'h000000
`define ESX_BYTE_RESET 8'h00

`endif

/* pkg/esx_pkg.sv */
// Types shared by the extended stack instruction unit
// Assumes the defines header sits on the include path
package esx_pkg;
	typedef enum logic [1:0] {
		ESX_DEC,
		ESX_MVSF,
		ESX_MVSS,
		ESX_IDLE
	} esx_state_e;
	typedef logic [11:0] esx_addr_t;
	typedef logic [20:0] esx_pc_t;
endpackage : esx_pkg

/* verilog/esx_ind_detect.sv */
// Match of a data address against the block of indirect-addressing registers
// Assumes the block is contiguous, starting at BASE, COUNT entries long
`timescale 1ns/10ps
`include "esx_defines.svh"
module esx_ind_detect import esx_pkg::*; #(
	parameter int COUNT = `ESX_IND_COUNT,
	parameter logic [11:0] BASE = `ESX_IND_BASE
) (
	input wire esx_addr_t addr,
	output logic hit
);
	logic [COUNT-1:0] match;

	genvar gi;
	generate
		for (gi = 0; gi < COUNT; gi++) begin : g_cmp
			assign match[gi] = (addr == 12'(BASE + 12'(gi)));
		end
	endgenerate

	assign hit = |match;
endmodule : esx_ind_detect

/* tb/tb_top.sv */
// Self-checking bench for the extended stack instruction unit
// Assumes esx_pkg and esx_defines.svh are compiled first; all stimulus at the falling edge
`timescale 1ns/10ps
module tb_top import esx_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ext_enable = 1'b1;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	esx_pc_t pc = 21'h0000F0;
	esx_pc_t rtop = 21'h012345;
	logic [7:0] acc = 8'h06;
	logic [7:0] hi = 8'h10;
	logic [7:0] up = 8'hE1;
	logic [3:0] bank = 4'h3;
	logic std_valid = 1'b0;
	logic [7:0] std_file = 8'h00;
	logic std_access = 1'b0;
	logic ptr_load = 1'b0;
	logic [1:0] ptr_sel = 2'h0;
	esx_addr_t ptr_value = 12'h000;
	logic [7:0] rdd = 8'h33;
	logic claim, busy, push, pop, counter_low_byte, rd_en, wr_en, eff_v;
	esx_pc_t pushv, pclv;
	esx_addr_t rd_a, wr_a, eff_a, p0, p1, p2;
	logic [7:0] wr_d;
	int err_total = 0;
	int n_checks = 0;

	always #4 clk = ~clk;

	esx_unit DUT (.clk(clk), .rst(rst), .ext_enable(ext_enable), .instr_valid(instr_valid),
		.instr_word(instr_word), .pc(pc), .accumulator_reg(acc), .counter_high_latch(hi),
		.counter_upper_latch(up), .return_stack_top(rtop), .bank_selector(bank),
		.std_valid(std_valid), .std_file(std_file), .std_access(std_access),
		.ptr_load(ptr_load), .ptr_sel(ptr_sel), .ptr_value(ptr_value), .mem_rd_data(rdd),
		.claim_r(claim), .busy_r(busy), .stack_push_r(push), .stack_push_value_r(pushv),
		.stack_pop_r(pop), .pc_load_r(counter_low_byte), .pc_load_value_r(pclv), .mem_rd_en_r(rd_en),
		.mem_rd_addr_r(rd_a), .mem_wr_en_r(wr_en), .mem_wr_addr_r(wr_a),
		.mem_wr_data_r(wr_d), .eff_valid_r(eff_v), .eff_addr_r(eff_a),
		.pointer0(p0), .pointer1(p1), .pointer2(p2));

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	task chk(input logic [20:0] got, input logic [20:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// One word presented for one cycle; returns when its answer is visible
	task op(input logic [15:0] w);
		@(negedge clk);
		instr_valid = 1'b1;
		instr_word = w;
		@(negedge clk);
		instr_valid = 1'b0;
	endtask : op

	task ld(input logic [1:0] sel, input logic [11:0] v);
		@(negedge clk);
		ptr_load = 1'b1;
		ptr_sel = sel;
		ptr_value = v;
		@(negedge clk);
		ptr_load = 1'b0;
	endtask : ld

	task t_call;
		op(16'h0014);
		chk(push, 1, "push");
		chk(pushv, 21'h0000F2, "return address");
		chk(counter_low_byte, 1, "pc load");
		chk(pclv, 21'h011006, "call target");
		chk(busy, 1, "call busy");
		@(negedge clk);
		chk({claim, push, counter_low_byte, busy}, 0, "call idle cycle");
	endtask : t_call

	task t_sub;
		ld(2, 12'h3FF);
		op(16'hE9A3);
		chk(claim, 1, "sub claim");
		chk(p2, 12'h3DC, "sub frame");
		ld(0, 12'h005);
		op(16'hE923);
		chk(p0, 12'hFE2, "sub wrap");
		ld(1, 12'h040);
		op(16'hE97F);
		chk(p1, 12'h001, "sub max literal");
		op(16'hE9E3);
		chk({pop, counter_low_byte, busy}, 3'h7, "return pulses");
		chk(pclv, 21'h012345, "return target");
		chk(p2, 12'h3B9, "return frame");
		@(negedge clk);
		chk({claim, pop, counter_low_byte, busy}, 0, "return idle cycle");
	endtask : t_sub

	task t_push(input logic [11:0] f, input logic [7:0] k, input logic [11:0] nf);
		ld(2, f);
		op({8'hFA, k});
		chk(wr_en, 1, "push write");
		chk({wr_a, wr_d}, {f, k}, "push address data");
		chk(p2, nf, "push decrement");
	endtask : t_push

	// Two pushes back to back, the second using the frame pointer left by the first
	task t_push_pair;
		ld(2, 12'h100);
		@(negedge clk);
		instr_valid = 1'b1;
		instr_word = 16'hFA11;
		@(negedge clk);
		chk({wr_a, wr_d}, {12'h100, 8'h11}, "first push");
		chk(p2, 12'h0FF, "first push decrement");
		instr_word = 16'hFA22;
		@(negedge clk);
		instr_valid = 1'b0;
		chk(wr_en, 1, "second push write");
		chk({wr_a, wr_d}, {12'h0FF, 8'h22}, "second push");
		chk(p2, 12'h0FE, "second push decrement");
	endtask : t_push_pair

	// Destinations avoid counter and stack-top registers
	task t_move(input logic [11:0] f, input logic [15:0] w1, input logic [15:0] w2,
			input logic [11:0] ra, input logic we, input logic [11:0] wa, input logic [7:0] wd);
		ld(2, f);
		@(negedge clk);
		instr_valid = 1'b1;
		instr_word = w1;
		@(negedge clk);
		chk({rd_en, busy}, 2'h3, "move read");
		chk(rd_a, ra, "move source");
		instr_word = w2;
		@(negedge clk);
		instr_valid = 1'b0;
		chk(wr_en, we, "move write enable");
		if (we)
			chk({wr_a, wr_d}, {wa, wd}, "move destination");
	endtask : t_move

	task t_std(input logic a, input logic [7:0] f, input logic [11:0] ea);
		@(negedge clk);
		std_valid = 1'b1;
		std_access = a;
		std_file = f;
		@(negedge clk);
		std_valid = 1'b0;
		chk(eff_v, 1, "operand valid");
		chk(eff_a, ea, "operand address");
	endtask : t_std

	task t_disabled;
		ext_enable = 1'b0;
		op(16'h0014);
		chk({claim, push, counter_low_byte, busy}, 0, "call while disabled");
		op(16'hFA08);
		chk({claim, wr_en}, 0, "push while disabled");
		ld(2, 12'hA00);
		t_std(1'b0, 8'h2C, 12'h02C);
		t_std(1'b0, 8'h80, 12'hF80);
		t_std(1'b1, 8'h2C, 12'h32C);
		ext_enable = 1'b1;
	endtask : t_disabled

	initial begin
		#200000;
		err_total++;
		close_out;
	end

	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk(p0, 0, "pointer0 after reset");
		chk(p1, 0, "pointer1 after reset");
		chk(p2, 0, "pointer2 after reset");
		chk({claim, busy, push, pop, counter_low_byte, rd_en, wr_en, eff_v}, 0, "pulses after reset");
		t_call;
		t_sub;
		t_push(12'h1EC, 8'h08, 12'h1EB);
		t_push(12'h000, 8'hFF, 12'hFFF);
		t_push_pair;
		t_move(12'h080, 16'hEB05, 16'hFFFF, 12'h085, 1'b1, 12'hFFF, 8'h33);
		t_move(12'hFD0, 16'hEB05, 16'hF010, 12'hFD5, 1'b1, 12'h010, 8'h00);
		t_move(12'h080, 16'hEB85, 16'hF006, 12'h085, 1'b1, 12'h086, 8'h33);
		t_move(12'hF80, 16'hEB85, 16'hF055, 12'hF85, 1'b0, 12'h000, 8'h00);
		t_move(12'h080, 16'hEB05, 16'h0123, 12'h085, 1'b0, 12'h000, 8'h00);
		ld(2, 12'hA00);
		t_std(1'b0, 8'h2C, 12'hA2C);
		t_std(1'b0, 8'h5F, 12'hA5F);
		t_std(1'b0, 8'h60, 12'hF60);
		t_std(1'b1, 8'h2C, 12'h32C);
		ld(2, 12'h000);
		t_std(1'b0, 8'h2C, 12'h02C);
		t_disabled;
		close_out;
	end
endmodule : tb_top
